// [hw/twms_pkg.sv]
/* Shared constants and types of the two-wire master sequencer.
   Assumes: compiled before hw/twms_top.sv. */
package twms_pkg;
    // ****************
    // Register map
    // ****************
    localparam int         AW       = 8;
    localparam logic [7:0] A_CMD    = 8'h00;
    localparam logic [7:0] A_NCMD   = 8'h04;
    localparam logic [7:0] A_RHR    = 8'h08;
    localparam logic [7:0] A_THR    = 8'h0c;
    localparam logic [7:0] A_STAT   = 8'h10;
    localparam logic [7:0] A_DIV    = 8'h14;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ****************
    // Byte framing
    // ****************
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [4:0] TEN_HDR  = 5'h1e;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ALL_ONES = 8'hff;
    // ****************
    // Types
    // ****************
    typedef struct packed {
        logic       valid;
        logic [7:0] byte_count;
        logic       ten_bit_address_enable;
        logic       repeat_same_address;
        logic       ack_final_byte;
        logic       stop;
        logic       start;
        logic       read;
        logic [9:0] addr;
    } twms_cmd_t;
    localparam int        CMD_W   = $bits(twms_cmd_t);
    localparam twms_cmd_t CMD_RST = '0;
    typedef struct packed {
        logic hs_master_code_ack_flag;
        logic arbLost;
        logic data_nack_flag;
        logic address_nack_flag;
        logic command_complete_flag;
        logic txEmpty;
        logic rxFull;
    } twms_stat_t;
    localparam int         STAT_W   = $bits(twms_stat_t);
    localparam twms_stat_t STAT_RST = 7'h02;
    localparam logic [6:0] STAT_W1C = 7'h7c;
    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_START  = 4'h1,
        S_LOAD   = 4'h3,
        S_BLO    = 4'h2,
        S_BHI    = 4'h6,
        S_NEXT   = 4'h7,
        S_STOPLO = 4'h5,
        S_STOPHI = 4'h4,
        S_RS     = 4'hc,
        S_LOST   = 4'hd
    } twms_state_t;
    typedef enum logic [1:0] {K_ADR1 = 2'h0, K_ADR2 = 2'h1, K_DATA = 2'h3} twms_kind_t;
endpackage : twms_pkg

// [hw/twms_top.sv]
/* Two-wire bus master sequencer with AXI4-Lite registers.
   Assumes: open-drain lines pulled up outside; pins arrive asynchronous to clk.
// Summary of operation
// R1: Receiving, clock held low while receive holding register is full.
// R2: Each received byte goes to holding register, full flag set.
// R3: Last byte of a read answered with NACK, others with ACK.
// R4: Byte count decremented per byte; at zero with stop, STOP sent.
// R5: Read with start, stop and zero count gives START, address, STOP.
// R6: Ninth pulse of a read byte: master drives the acknowledge.
// R7: Receive full flag doubles as DMA receive request.
// R8: Software sets up DMA, programs command, waits end flag, disables.
// R9: Arbitration lost when driving one but bus reads zero.
// R10: After loss: stop driving, flag it, wait for STOP.
// R11: Bus occupied by another master: wait for STOP before START.
// R12: No busy or free bus status bit is visible.
// R13: Next command with start after no-stop command: repeated START.
// R14: Commands without start or stop continue the transfer.
// R15: Acknowledge-final-byte bit makes the last byte ACKed.
// R16: Software writes and reads data only when flags allow.
// R17: Each command carries start, stop, address, count, direction.
// R18: Ten-bit enable gives ten-bit addressing using upper address bits.
// R19: Ten-bit write is one command with start and stop.
// R20: Repeat-same-address with ten-bit sends only first byte with read.
// R21: No new transfer while a nack, loss or master code flag set.
// R22: On loss both lines released, no completion, command kept valid.
// R23: Finished command replaced by valid next command automatically.
// R24: Data line checked during every bit driven high.
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
module twms_top
    import twms_pkg::*;
#(
    parameter int                DIV_W   = 16,
    parameter logic [DIV_W-1:0]  DIV_RST = 4
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic                   awvalid,
    output      logic                   awready,
    input  wire logic [twms_pkg::AW-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   wvalid,
    output      logic                   wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    output      logic                   bvalid,
    input  wire logic                   bready,
    output      logic [1:0]             bresp,
    input  wire logic                   arvalid,
    output      logic                   arready,
    input  wire logic [twms_pkg::AW-1:0] araddr,
    input  wire logic [2:0]             arprot,
    output      logic                   rvalid,
    input  wire logic                   rready,
    output      logic [31:0]            rdata,
    output      logic [1:0]             rresp,
    input  wire logic                   sclIn,
    output      logic                   sclOut,
    output      logic                   sclOe,
    input  wire logic                   sdaIn,
    output      logic                   sdaOut,
    output      logic                   sdaOe,
    output      logic                   dmaRxReq
);
    if (DIV_W < 2 || DIV_W > 16 || DIV_RST == 0) begin : g_chk
        $error("twms_top: unsupported divider setting");
    end

    function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction : strbMerge

    function automatic logic isMapped(input logic [AW-1:0] a);
        return a inside {A_CMD, A_NCMD, A_RHR, A_THR, A_STAT, A_DIV};
    endfunction : isMapped

    logic [1:0]       sclSync_reg, sdaSync_reg;
    logic             sdaPrev_reg, busy_reg, lowDrive_reg;
    twms_state_t      state_reg;
    twms_kind_t       kind_reg;
    logic [3:0]       bitCnt_reg;
    logic [8:0]       shift_reg;
    logic [7:0]       rx_reg, rhr_reg, thr_reg;
    logic [DIV_W-1:0] cnt_reg, div_reg;
    logic             sclOe_reg, sdaOe_reg;
    twms_cmd_t        cmd_reg, ncmd_reg;
    twms_stat_t       stat_reg;
    logic             awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]       bresp_reg, rresp_reg;
    logic [31:0]      rdata_reg, wData_reg;
    logic [AW-1:0]    awAddr_reg;
    logic [3:0]       wStrb_reg;
    logic             scl, sda, startSeen, stopSeen, errs, readData, lastBit;
    logic             usDrive, sclWait, arbLose, bitEnd, byteEnd, addrNak, dataNak;
    logic             rxByte, addrFinal, doneEv, loadOk, txTake, wrGo, rdGo;

    assign scl       = sclSync_reg[1];
    assign sda       = sdaSync_reg[1];
    assign startSeen = scl && sdaPrev_reg && !sda;
    assign stopSeen  = scl && !sdaPrev_reg && sda;
    assign errs      = stat_reg.address_nack_flag | stat_reg.data_nack_flag | stat_reg.arbLost | stat_reg.hs_master_code_ack_flag;
    assign readData  = kind_reg == K_DATA && cmd_reg.read;
    assign lastBit   = bitCnt_reg == BIT_LAST;
    assign usDrive   = readData ? lastBit : !lastBit; // R6
    assign sclWait   = !scl && (state_reg == S_BHI || state_reg == S_STOPHI
                                || (state_reg == S_RS && !sclOe_reg));
    assign arbLose   = state_reg == S_BHI && scl && usDrive && shift_reg[8] && !sda; // R9 R24
    assign bitEnd    = state_reg == S_BHI && scl && cnt_reg == '0 && !arbLose;
    assign byteEnd   = bitEnd && lastBit;
    assign addrNak   = byteEnd && kind_reg != K_DATA && sda;
    assign dataNak   = byteEnd && kind_reg == K_DATA && !cmd_reg.read && sda;
    assign rxByte    = byteEnd && readData;
    assign addrFinal = kind_reg == K_ADR2 || !cmd_reg.ten_bit_address_enable || cmd_reg.repeat_same_address;
    assign doneEv    = byteEnd && !addrNak && !dataNak
                       && (kind_reg == K_DATA ? cmd_reg.byte_count == ONE_BYTE
                                              : addrFinal && cmd_reg.byte_count == '0); // R5
    assign loadOk    = kind_reg != K_DATA
                       || (cmd_reg.read ? !stat_reg.rxFull : !stat_reg.txEmpty);
    assign txTake    = state_reg == S_LOAD && kind_reg == K_DATA && !cmd_reg.read
                       && !stat_reg.txEmpty;
    assign wrGo      = !awready_reg && !wready_reg && !bvalid_reg;
    assign rdGo      = arvalid && arready_reg;

    // ****************
    // Line sampling and bus occupancy
    // ****************
    always_ff @(posedge clk) begin
        if (rst) begin
            sclSync_reg  <= 2'h3;
            sdaSync_reg  <= 2'h3;
            sdaPrev_reg  <= 1'b1;
            busy_reg     <= 1'b0;
            lowDrive_reg <= 1'b0;
        end else if (ce) begin
            sclSync_reg <= {sclSync_reg[0], sclIn};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sdaPrev_reg <= sda;
            if (startSeen) begin
                busy_reg <= 1'b1;
            end else if (stopSeen) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // ****************
    // Bit sequencer
    // ****************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg  <= S_IDLE;
            kind_reg   <= K_ADR1;
            sclOe_reg  <= 1'b0;
            sdaOe_reg  <= 1'b0;
            cnt_reg    <= '0;
            bitCnt_reg <= '0;
            shift_reg  <= '0;
            rx_reg     <= '0;
        end else if (ce) begin
            if (cnt_reg != '0 && !sclWait) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            unique case (state_reg)
                S_IDLE: if (cmd_reg.valid && !errs && !busy_reg) begin // R11 R21
                    sdaOe_reg <= 1'b1;
                    cnt_reg   <= div_reg;
                    state_reg <= S_START;
                end
                S_START: if (cnt_reg == '0) begin
                    sclOe_reg <= 1'b1;
                    kind_reg  <= cmd_reg.start ? K_ADR1 : K_DATA;
                    state_reg <= S_LOAD;
                end
                S_LOAD: if (loadOk) begin // R1
                    unique case (kind_reg)
                        K_ADR1: shift_reg <= cmd_reg.ten_bit_address_enable // R17 R18 R20
                            ? {TEN_HDR, cmd_reg.addr[9:8], cmd_reg.repeat_same_address & cmd_reg.read, 1'b1}
                            : {cmd_reg.addr[6:0], cmd_reg.read, 1'b1};
                        K_ADR2: shift_reg <= {cmd_reg.addr[7:0], 1'b1};
                        default: shift_reg <= cmd_reg.read // R3 R15
                            ? {ALL_ONES, cmd_reg.byte_count == ONE_BYTE && !cmd_reg.ack_final_byte}
                            : {thr_reg, 1'b1};
                    endcase
                    bitCnt_reg <= '0;
                    cnt_reg    <= div_reg;
                    state_reg  <= S_BLO;
                end
                S_BLO: begin
                    sdaOe_reg <= !shift_reg[8];
                    if (cnt_reg == '0) begin
                        sclOe_reg <= 1'b0;
                        cnt_reg   <= div_reg;
                        state_reg <= S_BHI;
                    end
                end
                S_BHI: if (arbLose) begin
                    sclOe_reg <= 1'b0; // R10 R22
                    sdaOe_reg <= 1'b0;
                    state_reg <= S_LOST;
                end else if (bitEnd) begin
                    sclOe_reg  <= 1'b1;
                    shift_reg  <= {shift_reg[7:0], 1'b1};
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                    cnt_reg    <= div_reg;
                    if (!lastBit) begin
                        rx_reg    <= {rx_reg[6:0], sda};
                        state_reg <= S_BLO;
                    end else if (addrNak || dataNak || (doneEv && cmd_reg.stop)) begin
                        state_reg <= S_STOPLO; // R4
                    end else if (doneEv) begin
                        state_reg <= S_NEXT;
                    end else begin
                        kind_reg  <= kind_reg == K_ADR1 && cmd_reg.ten_bit_address_enable && !cmd_reg.repeat_same_address
                                     ? K_ADR2 : K_DATA;
                        state_reg <= S_LOAD;
                    end
                end
                S_STOPLO: begin
                    sdaOe_reg <= 1'b1;
                    if (cnt_reg == '0) begin
                        sclOe_reg <= 1'b0;
                        cnt_reg   <= div_reg;
                        state_reg <= S_STOPHI;
                    end
                end
                S_STOPHI: if (cnt_reg == '0 && scl) begin
                    sdaOe_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
                S_NEXT: if (cmd_reg.valid && !errs) begin
                    cnt_reg <= div_reg;
                    if (cmd_reg.start) begin
                        sdaOe_reg <= 1'b0; // R13
                        state_reg <= S_RS;
                    end else begin
                        kind_reg  <= K_DATA; // R14
                        state_reg <= S_LOAD;
                    end
                end
                S_RS: if (cnt_reg == '0 && (sclOe_reg || scl)) begin
                    cnt_reg <= div_reg;
                    if (sclOe_reg) begin
                        sclOe_reg <= 1'b0;
                    end else begin
                        sdaOe_reg <= 1'b1;
                        state_reg <= S_START;
                    end
                end
                S_LOST: if (stopSeen) begin
                    state_reg <= S_IDLE; // R10
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ****************
    // Registers and flags
    // ****************
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_reg  <= CMD_RST;
            ncmd_reg <= CMD_RST;
            stat_reg <= STAT_RST;
            rhr_reg  <= '0;
            thr_reg  <= '0;
            div_reg  <= DIV_RST;
        end else if (ce) begin
            if (wrGo) begin
                case (awAddr_reg)
                    A_CMD:  cmd_reg  <= CMD_W'(strbMerge(32'(cmd_reg), wData_reg, wStrb_reg));
                    A_NCMD: ncmd_reg <= CMD_W'(strbMerge(32'(ncmd_reg), wData_reg, wStrb_reg));
                    A_THR: begin
                        thr_reg          <= wData_reg[7:0];
                        stat_reg.txEmpty <= 1'b0;
                    end
                    A_STAT: stat_reg <= stat_reg & ~(wData_reg[STAT_W-1:0] & STAT_W1C);
                    A_DIV:  div_reg  <= DIV_W'(strbMerge(32'(div_reg), wData_reg, wStrb_reg));
                    default: ;
                endcase
            end
            if (rdGo && araddr == A_RHR) begin
                stat_reg.rxFull <= 1'b0;
            end
            if (rxByte) begin
                rhr_reg         <= rx_reg; // R2
                stat_reg.rxFull <= 1'b1; // R7
            end
            if (txTake) begin
                stat_reg.txEmpty <= 1'b1;
            end
            if (addrNak) begin
                stat_reg.address_nack_flag <= 1'b1;
            end
            if (dataNak) begin
                stat_reg.data_nack_flag <= 1'b1;
            end
            if (arbLose) begin
                stat_reg.arbLost <= 1'b1; // R10
            end
            if (byteEnd && kind_reg == K_DATA && !dataNak) begin
                cmd_reg.byte_count <= cmd_reg.byte_count - ONE_BYTE; // R4
            end
            if (doneEv) begin
                stat_reg.command_complete_flag <= 1'b1;
                cmd_reg        <= ncmd_reg; // R23
                if (!(wrGo && awAddr_reg == A_NCMD)) begin
                    ncmd_reg.valid <= 1'b0;
                end
            end
        end
    end

    // ****************
    // AXI4-Lite slave
    // ****************
    always_ff @(posedge clk) begin
        if (rst) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OK;
            awAddr_reg  <= '0;
            wData_reg   <= '0;
            wStrb_reg   <= '0;
        end else if (ce) begin
            if (awvalid && awready_reg) begin
                awAddr_reg  <= awaddr;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                wData_reg  <= wdata;
                wStrb_reg  <= wstrb;
                wready_reg <= 1'b0;
            end
            if (wrGo) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= isMapped(awAddr_reg) ? RESP_OK : RESP_ERR;
            end
            if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OK;
            rdata_reg   <= '0;
        end else if (ce) begin
            if (rdGo) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= isMapped(araddr) ? RESP_OK : RESP_ERR;
                case (araddr)
                    A_CMD:   rdata_reg <= 32'(cmd_reg);
                    A_NCMD:  rdata_reg <= 32'(ncmd_reg);
                    A_RHR:   rdata_reg <= 32'(rhr_reg);
                    A_STAT:  rdata_reg <= 32'(stat_reg); // R12
                    A_DIV:   rdata_reg <= 32'(div_reg);
                    default: rdata_reg <= '0;
                endcase
            end
            if (rvalid_reg && rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    assign awready  = awready_reg;
    assign wready   = wready_reg;
    assign bvalid   = bvalid_reg;
    assign bresp    = bresp_reg;
    assign arready  = arready_reg;
    assign rvalid   = rvalid_reg;
    assign rdata    = rdata_reg;
    assign rresp    = rresp_reg;
    assign sclOut   = lowDrive_reg;
    assign sdaOut   = lowDrive_reg;
    assign sclOe    = sclOe_reg;
    assign sdaOe    = sdaOe_reg;
    assign dmaRxReq = stat_reg.rxFull;

    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    stretch_hold_a: assert property (state_reg == S_LOAD && readData && stat_reg.rxFull |-> sclOe_reg) else $error("Clock released while receive register full"); // R1
    rx_store_a: assert property (ce && rxByte |=> stat_reg.rxFull && rhr_reg == $past(rx_reg)) else $error("Received byte not stored"); // R2
    ack_choice_a: assert property (ce && state_reg == S_LOAD && readData && !stat_reg.rxFull |=> shift_reg[0] == ($past(cmd_reg.byte_count) == ONE_BYTE && !$past(cmd_reg.ack_final_byte))) else $error("Wrong acknowledge choice"); // R3
    count_dec_a: assert property (ce && byteEnd && kind_reg == K_DATA && !dataNak && !doneEv && !wrGo |=> cmd_reg.byte_count == $past(cmd_reg.byte_count) - ONE_BYTE) else $error("Byte count not decremented"); // R4
    arb_release_a: assert property (ce && arbLose |=> !sclOe_reg && !sdaOe_reg && stat_reg.arbLost && state_reg == S_LOST) else $error("Lines not released on loss"); // R22
    lost_wait_a: assert property (state_reg == S_LOST && !stopSeen |=> state_reg == S_LOST) else $error("Left lost state before stop"); // R10
    busy_wait_a: assert property (state_reg == S_IDLE && busy_reg |=> state_reg == S_IDLE) else $error("Started on busy bus"); // R11
    err_block_a: assert property (state_reg == S_IDLE && errs |=> state_reg == S_IDLE) else $error("Started with error flag set"); // R21
    cmd_move_a: assert property (ce && doneEv && !wrGo |=> cmd_reg == $past(ncmd_reg)) else $error("Next command not moved"); // R23
    rx_byte_c: cover property (rxByte);
    arb_lose_c: cover property (arbLose);
    rep_start_c: cover property (state_reg == S_RS);
endmodule : twms_top

// [verification/twms_slave_model.sv]
/* Behavioural slave on the two-wire bus: acks its address, sends a byte ramp.
   Assumes: open-drain lines with pull-ups, resolved by the bench. */
module twms_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] base,
    input  wire logic       nackAddr,
    input  wire logic       arbLow,
    output logic            sdaLow,
    output logic [7:0]      adrByte,
    output logic [7:0]      ackHist,
    output int              nStart
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       act;
    logic       adrPh;
    logic       rdDir;
    int         bitN;
    initial begin
        sdaLow = 1'b0;
        act = 1'b0;
        nStart = 0;
        ackHist = 8'h00;
    end
    // Start or repeated start
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        adrPh = 1'b1;
        rdDir = 1'b0;
        bitN = 0;
        nStart++;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    // Other master lets go of the data line
    always @(negedge arbLow) sdaLow = 1'b0;
    always @(posedge scl) if (act) begin
        if (bitN < 8) sh = {sh[6:0], sda};
        else if (adrPh) begin
            adrByte = sh;
            rdDir = sh[0];
        end else if (rdDir) begin
            ackHist = {ackHist[6:0], ~sda};
            act = ~sda;
        end
        bitN++;
    end
    always @(negedge scl) if (act) begin
        if (bitN == 9) begin
            bitN = 0;
            tx = adrPh ? base : tx + 8'h01;
            adrPh = 1'b0;
        end
        if (bitN == 8) sdaLow = adrPh ? ~nackAddr : ~rdDir;
        else sdaLow = arbLow | (rdDir & ~adrPh & ~tx[7 - bitN]);
    end
endmodule : twms_slave_model

// [verification/test_two_wire_master_sequencer.sv]
/* Self-checking bench: AXI4-Lite master, open-drain bus, behavioural slave.
   Assumes: package, design and slave model compiled first. */
module test_two_wire_master_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import twms_pkg::*;
    logic        clk = 0, rst = 1, ce = 1, awvalid = 0, wvalid = 0, arvalid = 0, nackAddr = 0;
    logic        arbLow = 0, awready, wready, bvalid, arready, rvalid, sclOe, sdaOe;
    logic        sdaLow, dmaRxReq, scl, sda, sclOut, sdaOut;
    logic [7:0]  awaddr = 0, araddr = 0, base = 0, adrByte, ackHist;
    logic [31:0] wdata = 0, rd, rdata;
    logic [1:0]  rs, bresp, rresp;
    logic [9:0]  a;
    logic [7:0]  q[$];
    int          nStart, st, k, cyc = 0, error_cnt = 0, n_compared = 0;
    assign scl = ~sclOe;
    assign sda = ~(sdaOe | sdaLow);
    always #12.5 clk = ~clk;
    twms_top i_dut (.clk(clk), .rst(rst), .ce(ce), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
        .rdata(rdata), .rresp(rresp), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .dmaRxReq(dmaRxReq));
    twms_slave_model i_slv (.scl(scl), .sda(sda), .base(base), .nackAddr(nackAddr),
        .arbLow(arbLow), .sdaLow(sdaLow), .adrByte(adrByte), .ackHist(ackHist), .nStart(nStart));
    // ****************
    // Bus tasks
    // ****************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic axiWr(input logic [7:0] ad, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        {awaddr, wdata, awvalid, wvalid} <= {ad, d, 2'b11};
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        chk("bresp", RESP_OK, bresp);
    endtask : axiWr
    task automatic axiRd(input logic [7:0] ad);
        {araddr, arvalid} <= {ad, 1'b1};
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        {rd, rs} = {rdata, rresp};
    endtask : axiRd
    task automatic poll(input logic [7:0] ad, input int b, input logic v);
        k = 0;
        do begin
            axiRd(ad);
            k++;
        end while (rd[b] !== v && k < 1000);
        chk("poll", v, rd[b]);
    endtask : poll
    function automatic logic [31:0] cmd(input logic [9:0] ad, input logic r, s, p, t,
                                        input logic [7:0] nb);
        return {7'h00, 1'b1, nb, t, 1'b0, 1'b0, p, s, r, ad};
    endfunction : cmd
    task automatic runCmd(input logic [31:0] c, input logic [7:0] adr);
        st = nStart;
        axiWr(A_CMD, c);
        poll(A_CMD, 24, 1'b0);
        chk("adr", adr, adrByte);
        chk("starts", 1, nStart - st);
        axiRd(A_STAT);
        chk("stat", 32'h06, rd);
        axiWr(A_STAT, 32'h7c);
    endtask : runCmd
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // ****************
    // Scenarios
    // ****************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        st = $urandom(13166);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("dma", 0, dmaRxReq);
        chk("drv", 0, {sclOut, sdaOut});
        for (int j = 0; j < 7; j++) begin
            axiRd(8'(j * 4));
            chk("reset", j == 4 ? 32'h02 : (j == 5 ? 32'h04 : 32'h00), rd);
            chk("resp", j == 6 ? 2'h2 : 2'h0, rs);
        end
        base <= 8'($urandom);
        a = 10'($urandom % 128);
        st = nStart;
        axiWr(A_NCMD, cmd(a, 1'b1, 1'b1, 1'b1, 1'b0, 8'h01));
        axiWr(A_CMD, cmd(a, 1'b1, 1'b1, 1'b0, 1'b0, 8'h02));
        q = '{base, base + 8'h01, base};
        repeat (300) @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        chk("freeze", 1, dmaRxReq);
        foreach (q[j]) begin
            poll(A_STAT, 0, 1'b1);
            chk("dma", 1, dmaRxReq);
            axiRd(A_RHR);
            chk("rhr", {24'h0, q[j]}, rd);
        end
        poll(A_CMD, 24, 1'b0);
        chk("acks", 3'b100, ackHist[2:0]);
        chk("starts", 2, nStart - st);
        chk("adr", {a[6:0], 1'b1}, adrByte);
        st = nStart;
        axiWr(A_NCMD, cmd(a, 1'b1, 1'b0, 1'b1, 1'b0, 8'h01));
        axiWr(A_CMD, cmd(a, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01) | 32'h2000);
        for (int j = 0; j < 2; j++) begin
            poll(A_STAT, 0, 1'b1);
            axiRd(A_RHR);
            chk("chain", {24'h0, base + 8'(j)}, rd);
        end
        poll(A_CMD, 24, 1'b0);
        chk("ack_final_byte", 2'b10, ackHist[1:0]);
        chk("chain starts", 1, nStart - st);
        axiWr(A_STAT, 32'h7c);
        base <= 8'hff;
        a = 10'($urandom);
        runCmd(cmd(a, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00), {a[6:0], 1'b1});
        runCmd(cmd(a, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00), {5'h1e, a[9:8], 1'b0});
        nackAddr <= 1'b1;
        st = nStart;
        axiWr(A_CMD, cmd(a, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00));
        poll(A_STAT, 3, 1'b1);
        repeat (400) @(posedge clk);
        chk("retry", 1, nStart - st);
        nackAddr <= 1'b0;
        axiWr(A_STAT, 32'h08);
        poll(A_CMD, 24, 1'b0);
        axiWr(A_STAT, 32'h04);
        arbLow <= 1'b1;
        axiWr(A_CMD, cmd(10'h07f, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00));
        poll(A_STAT, 5, 1'b1);
        chk("lines", 0, {sclOe, sdaOe});
        axiRd(A_STAT);
        chk("command_complete_flag", 0, rd[2]);
        arbLow <= 1'b0;
        axiWr(A_STAT, 32'h20);
        poll(A_CMD, 24, 1'b0);
        summarize();
    end
endmodule : test_two_wire_master_sequencer
